// file: common/power_save_pkg.sv
// power saving control constants and types
// assumes one 125 MHz system clock, synchronous active-low reset
package power_save_pkg;
    // power-save instruction operand
    localparam logic MODE_SLEEP = 1'b0;
    localparam logic MODE_IDLE = 1'b1;
    // clock divider register field positions
    localparam int RATIO_LSB = 12;
    localparam int RATIO_MSB = 14;
    localparam int SLOWDOWN_EN_BIT = 11;
    localparam int RETURN_ON_INT_BIT = 15;
    // reset values
    localparam logic [2:0] RATIO_RESET = 3'h0;
    localparam logic SLOWDOWN_RESET = 1'b0;
    localparam logic RETURN_RESET = 1'b0;
    localparam logic [2:0] OSC_RESET = 3'h0;
    // idle wake resume delay in clock cycles (2 to 4 allowed)
    localparam logic [2:0] IDLE_RESUME_CYCLES = 3'h2;
    localparam int DIV_WIDTH = 7;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_ENTER = 2'b01,
        ST_SLEEP = 2'b10,
        ST_IDLE = 2'b11
    } power_state_e;
endpackage : power_save_pkg

// file: core/power_saving_mode_control.sv
// power saving mode control: sleep, idle and core slowdown
// assumes wake sources and strobes are synchronous to clock; pin wake is synchronised here
`timescale 1ns/100ps
// What this block does
// - sleep request stops system, oscillator, peripheral and core clocks and halts execution until wake
// - idle request halts core and execution, peripherals keep clocks
// - entering sleep shuts down system clock source and on-chip oscillator
// - clock failure monitor disabled throughout sleep
// - low-power rc clock runs during sleep when watchdog enabled
// - watchdog count cleared on sleep entry, in the same cycle the clocks stop
// - system-clocked peripherals off in sleep; change detect and external clock stay
// - leave sleep or idle on enabled interrupt, any reset, or watchdog timeout
// - wake from sleep resumes on the clock source active at entry
// - watchdog count cleared on idle entry
// - system clock stays on in idle; peripherals clocked unless disabled
// - rc clock runs in idle if watchdog or failure monitor enabled
// - idle wake restores core clock, execution resumes 2 to 4 cycles later
// - interrupt during power-save instruction is held until entry completes, then wakes
// - slowdown divides only the core clock; system and peripheral clocks unchanged
// - slow core enable aligned to fast clock so domains stay synchronised
// - slowdown active only while divider register bit 11 is set
// - ratio field bits 14:12 picks 1:1 to 1:128, default 1:1
// - return-on-interrupt bit 15 set makes interrupt restore full speed
// - with return-on-interrupt, interrupt clears slowdown enable in hardware
module power_saving_mode_control (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // power-save instruction
    input wire logic power_save_instruction,
    input wire logic power_save_mode,
    // wake sources
    input wire logic interrupt_pending,
    input wire logic watchdog_timeout,
    input wire logic device_reset,
    input wire logic change_notice_pin,
    // configuration
    input wire logic watchdog_enable,
    input wire logic monitor_enable,
    input wire logic clock_divider_write,
    input wire logic [15:0] clock_divider_wdata,
    input wire logic new_oscillator_write,
    input wire logic [2:0] new_oscillator_select,
    input wire logic clock_config_locked,
    // clock and core controls
    output logic system_clock_enable,
    output logic onchip_osc_enable,
    output logic [2:0] active_oscillator,
    output logic low_power_rc_clock_enable,
    output logic clock_failure_monitor_active,
    output logic watchdog_counter_clear,
    output logic peripheral_clock_enable,
    output logic core_clock_enable,
    output logic core_halted,
    output logic wake_interrupt,
    // divider register view
    output logic core_slowdown_enable,
    output logic return_on_interrupt,
    output logic [2:0] slowdown_ratio
);
    import power_save_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // state
    power_state_e state;
    power_state_e next_state;
    logic held_interrupt;
    logic [2:0] resume_count;
    logic [DIV_WIDTH-1:0] div_count;
    logic pin_meta;
    logic pin_sync;
    logic pin_last;
    logic wake;
    logic pin_edge;
    logic [DIV_WIDTH-1:0] div_mask;
    logic slow_tick;
    logic idle_waking;

    assign pin_edge = pin_sync ^ pin_last;
    assign wake = interrupt_pending | held_interrupt | watchdog_timeout | pin_edge;
    // wake seen in idle: core stays off while the resume delay runs
    assign idle_waking = (state == ST_IDLE) && wake;

    ////////////////////////////////////////////////////////////////////////////////
    // change notice pin synchroniser (runs in sleep too)
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= change_notice_pin;
            pin_sync <= pin_meta;
        end
    end

    // previous synchronised level, for the edge detect
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pin_last <= 1'b0;
        end else begin
            pin_last <= pin_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // power state machine
    always_comb begin
        next_state = state;
        unique case (state)
            ST_RUN: begin
                if (power_save_instruction) begin
                    next_state = ST_ENTER;
                end
            end
            ST_ENTER: begin
                next_state = (power_save_mode == MODE_IDLE) ? ST_IDLE : ST_SLEEP;
            end
            ST_SLEEP: begin
                if (wake) begin
                    next_state = ST_RUN;
                end
            end
            ST_IDLE: begin
                if (wake) begin
                    next_state = ST_RUN;
                end
            end
        endcase
        // any device reset drops straight back to run
        if (device_reset) begin
            next_state = ST_RUN;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn || device_reset) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // interrupt coincident with the instruction is held until entry completes
    always_ff @(posedge clock) begin
        if (!resetn || device_reset) begin
            held_interrupt <= 1'b0;
        end else if (state == ST_RUN && !power_save_instruction) begin
            held_interrupt <= 1'b0;
        end else if (state == ST_RUN || state == ST_ENTER) begin
            held_interrupt <= held_interrupt | interrupt_pending;
        end else if (next_state == ST_RUN) begin
            held_interrupt <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // clock and watchdog controls
    always_ff @(posedge clock) begin
        if (!resetn) begin
            system_clock_enable <= 1'b1;
        end else begin
            system_clock_enable <= (next_state != ST_SLEEP);
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            onchip_osc_enable <= 1'b1;
        end else begin
            onchip_osc_enable <= (next_state != ST_SLEEP);
        end
    end

    // no system clock to watch in sleep
    always_ff @(posedge clock) begin
        if (!resetn) begin
            clock_failure_monitor_active <= 1'b0;
        end else begin
            clock_failure_monitor_active <= monitor_enable && (next_state != ST_SLEEP);
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            low_power_rc_clock_enable <= 1'b0;
        end else begin
            low_power_rc_clock_enable <= (next_state == ST_SLEEP) ? watchdog_enable
                : (watchdog_enable | monitor_enable);
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            peripheral_clock_enable <= 1'b1;
        end else begin
            peripheral_clock_enable <= (next_state != ST_SLEEP);
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            watchdog_counter_clear <= 1'b0;
        end else begin
            watchdog_counter_clear <= (state == ST_ENTER) && watchdog_enable;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            core_halted <= 1'b0;
        end else begin
            core_halted <= (next_state != ST_RUN) || idle_waking
                || (resume_count != 3'h0);
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            wake_interrupt <= 1'b0;
        end else begin
            wake_interrupt <= (state == ST_SLEEP || state == ST_IDLE) && wake
                && (interrupt_pending | held_interrupt);
        end
    end

    // idle wake delay before execution resumes
    always_ff @(posedge clock) begin
        if (!resetn || device_reset) begin
            resume_count <= 3'h0;
        end else if (state == ST_IDLE && wake) begin
            resume_count <= IDLE_RESUME_CYCLES;
        end else if (resume_count != 3'h0) begin
            resume_count <= resume_count - 3'h1;
        end
    end

    // clock source kept across sleep; only software changes it when unlocked
    always_ff @(posedge clock) begin
        if (!resetn) begin
            active_oscillator <= OSC_RESET;
        end else if (new_oscillator_write && !clock_config_locked && state == ST_RUN) begin
            active_oscillator <= new_oscillator_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // clock divider register
    always_ff @(posedge clock) begin
        if (!resetn) begin
            return_on_interrupt <= RETURN_RESET;
        end else if (clock_divider_write) begin
            return_on_interrupt <= clock_divider_wdata[RETURN_ON_INT_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            slowdown_ratio <= RATIO_RESET;
        end else if (clock_divider_write) begin
            slowdown_ratio <= clock_divider_wdata[RATIO_MSB:RATIO_LSB];
        end
    end

    // interrupt clear beats a write, unless that write drops return-on-interrupt
    always_ff @(posedge clock) begin
        if (!resetn) begin
            core_slowdown_enable <= SLOWDOWN_RESET;
        end else if (interrupt_pending && return_on_interrupt
            && (clock_divider_write ? clock_divider_wdata[RETURN_ON_INT_BIT] : 1'b1)) begin
            core_slowdown_enable <= 1'b0;
        end else if (clock_divider_write) begin
            core_slowdown_enable <= clock_divider_wdata[SLOWDOWN_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // core clock enable: one fast cycle in every 2^n
    // bit i of the mask passes when the ratio exceeds i
    for (genvar i = 0; i < DIV_WIDTH; i++) begin : g_mask
        assign div_mask[i] = (int'(slowdown_ratio) > i);
    end
    assign slow_tick = !core_slowdown_enable || ((div_count & div_mask) == '0);

    // free-running count; peripherals never see it
    always_ff @(posedge clock) begin
        if (!resetn) begin
            div_count <= '0;
        end else begin
            div_count <= div_count + DIV_WIDTH'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            core_clock_enable <= 1'b1;
        end else begin
            core_clock_enable <= (next_state == ST_RUN) && !idle_waking
                && (resume_count == 3'h0) && slow_tick;
        end
    end

endmodule : power_saving_mode_control

// file: test/core_partner.sv
// partner model: interrupt source of the core
// handler takes it at wake, otherwise the bench drops it
`timescale 1ns/100ps
module core_partner (
    input wire logic clock, resetn, raise_irq, drop_irq, wake_interrupt,
    output logic interrupt_pending
);
    always_ff @(posedge clock) begin
        if (!resetn || wake_interrupt || drop_irq) interrupt_pending <= 1'b0;
        else if (raise_irq) interrupt_pending <= 1'b1;
    end
endmodule : core_partner

// file: test/power_save_sva.sv
// assertions on power saving control ports
// bound into every power_saving_mode_control instance
`timescale 1ns/100ps
module power_save_sva (
    input wire logic clock, resetn, power_save_instruction, interrupt_pending, device_reset,
    input wire logic watchdog_enable, monitor_enable, clock_divider_write, system_clock_enable,
    input wire logic onchip_osc_enable, low_power_rc_clock_enable, clock_failure_monitor_active,
    input wire logic watchdog_counter_clear, peripheral_clock_enable, core_clock_enable,
    input wire logic core_halted, wake_interrupt, core_slowdown_enable, return_on_interrupt,
    input wire logic [2:0] active_oscillator, slowdown_ratio
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    logic [7:0] gap;
    logic [1:0] arm;
    always_ff @(posedge clock) begin
        gap <= (!resetn || core_clock_enable) ? 8'h00 : gap + 8'h01;
    end
    always_ff @(posedge clock) begin
        if (!resetn || clock_divider_write || !core_slowdown_enable || core_halted) arm <= 2'h0;
        else if (core_clock_enable && arm != 2'h3) arm <= arm + 2'h1;
    end
    sleep_off_a:
        assert property (!peripheral_clock_enable |-> !system_clock_enable && !onchip_osc_enable
            && !clock_failure_monitor_active && core_halted) else $error("clock on in sleep");
    rc_sleep_a:
        assert property (!peripheral_clock_enable |-> low_power_rc_clock_enable == watchdog_enable)
        else $error("rc clock wrong in sleep");
    rc_idle_a:
        assert property (core_halted && peripheral_clock_enable && (watchdog_enable
            || monitor_enable) |-> low_power_rc_clock_enable) else $error("rc off in idle");
    halt_entry_a:
        assert property (power_save_instruction && !core_halted && !device_reset |-> ##2
            core_halted && !core_clock_enable) else $error("no halt after request");
    wd_clear_a:
        assert property (power_save_instruction && !core_halted && watchdog_enable |-> ##2
            watchdog_counter_clear) else $error("no watchdog clear");
    idle_resume_a:
        assert property (wake_interrupt && $past(peripheral_clock_enable) && $past(core_halted)
            |-> !core_clock_enable [*3] ##1 core_clock_enable && !core_halted)
        else $error("idle resume delay wrong");
    osc_hold_a:
        assert property (core_halted |=> $stable(active_oscillator)) else $error("osc changed");
    slow_ratio_a:
        assert property (core_clock_enable && arm == 2'h3 |-> gap == (8'h01 << slowdown_ratio)
            - 8'h01 && peripheral_clock_enable && system_clock_enable) else $error("bad ratio");
    full_speed_a:
        assert property (!core_slowdown_enable && !$past(core_slowdown_enable) && !core_halted
            && !$past(core_halted) |-> core_clock_enable) else $error("core slowed");
    roi_clear_a:
        assert property (core_slowdown_enable && interrupt_pending && !clock_divider_write |=>
            core_slowdown_enable != return_on_interrupt) else $error("return on irq wrong");
    sleep_c: cover property (!peripheral_clock_enable);
    idle_c: cover property (core_halted && peripheral_clock_enable);
    slow_c: cover property (core_clock_enable && arm == 2'h3 && slowdown_ratio == 3'h7);
endmodule : power_save_sva
bind power_saving_mode_control power_save_sva i_power_save_sva (.*);

// file: test/testbench.sv
// bench for power saving control: wake sources, slowdown, oscillator select
// core_partner supplies interrupts, checker is bound separately
`timescale 1ns/100ps
module testbench;
    import power_save_pkg::*;
    logic clock = 1'b0, resetn = 1'b0, power_save_instruction = 1'b0, power_save_mode = 1'b0;
    logic watchdog_timeout = 1'b0, device_reset = 1'b0, change_notice_pin = 1'b0;
    logic watchdog_enable = 1'b0, monitor_enable = 1'b0, clock_divider_write = 1'b0;
    logic new_oscillator_write = 1'b0, clock_config_locked = 1'b0, raise_irq = 1'b0;
    logic drop_irq = 1'b0, interrupt_pending, system_clock_enable, onchip_osc_enable;
    logic low_power_rc_clock_enable, clock_failure_monitor_active, watchdog_counter_clear;
    logic peripheral_clock_enable, core_clock_enable, core_halted, wake_interrupt;
    logic core_slowdown_enable, return_on_interrupt;
    logic [15:0] clock_divider_wdata = 16'h0000;
    logic [2:0] new_oscillator_select = 3'h0, active_oscillator, slowdown_ratio, osc;
    logic [4:0] notes[$];
    int error_cnt = 0, checks_done = 0, cnt;
    power_saving_mode_control i_power_saving_mode_control (.*);
    core_partner i_core_partner (.*);
    initial forever #4 clock = ~clock;
    task automatic chk(string what, logic [9:0] e, logic [9:0] s);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, e, s);
        end
    endtask : chk
    task automatic tally_and_finish;
        chk("notes_left", 10'h0, 10'(notes.size()));
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    task automatic cyc(int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    task automatic pulse(logic [15:0] d, logic lock, logic [2:0] v, logic div);
        {clock_divider_wdata, clock_config_locked, new_oscillator_select} = {d, lock, v};
        {clock_divider_write, new_oscillator_write} = {div, !div};
        cyc(1);
        {clock_divider_write, new_oscillator_write} = 2'h0;
        cyc(2);
    endtask : pulse
    task automatic enter_wake(logic m, int s);
        {watchdog_enable, monitor_enable} = 2'($urandom);
        cyc(2);
        if (watchdog_enable) notes.push_back({2'b01, osc});
        if (s == 3) notes.push_back({2'b10, osc});
        {power_save_instruction, power_save_mode, raise_irq} = {1'b1, m, s == 3};
        cyc(1);
        {power_save_instruction, raise_irq} = 2'h0;
        cyc(2);
        if (s != 3) begin
            chk("clocks", {5'h0, m, m, m, m & monitor_enable,
                m ? (watchdog_enable | monitor_enable) : watchdog_enable},
                {5'h0, peripheral_clock_enable, system_clock_enable, onchip_osc_enable,
                clock_failure_monitor_active, low_power_rc_clock_enable});
            if (s == 0) notes.push_back({2'b10, osc});
            {raise_irq, watchdog_timeout, device_reset} = {s == 0, s == 1, s == 2};
            change_notice_pin = change_notice_pin ^ (s == 4);
            cyc(1);
            {raise_irq, watchdog_timeout, device_reset} = 3'h0;
        end
        cnt = 0;
        while (core_halted !== 1'b0 && cnt < 20) begin
            cyc(1);
            cnt++;
        end
        chk("halted", 10'h0, {9'h0, core_halted});
        if (cnt == 20) tally_and_finish();
    endtask : enter_wake
    always @(negedge clock) begin
        if (resetn && (wake_interrupt || watchdog_counter_clear)) begin
            chk("event", notes.size() ? notes.pop_front() : 10'h0,
                {wake_interrupt, watchdog_counter_clear, active_oscillator});
        end
    end
    initial begin
        void'($urandom(32'h8B2DD192));
        cyc(5);
        resetn = 1'b1;
        cyc(1);
        chk("reset", {1'b0, SLOWDOWN_RESET, RETURN_RESET, 1'b0, OSC_RESET, RATIO_RESET},
            {1'b0, core_slowdown_enable, return_on_interrupt, 1'b0, active_oscillator, slowdown_ratio});
        osc = 3'($urandom) | 3'h1;
        pulse(16'h0, 1'b0, osc, 1'b0);
        chk("osc", {7'h0, osc}, {7'h0, active_oscillator});
        pulse(16'h0, 1'b1, ~osc, 1'b0);
        chk("osc_locked", {7'h0, osc}, {7'h0, active_oscillator});
        for (int m = 0; m < 2; m++) for (int s = 0; s < 5 - m; s++) enter_wake(m[0], s);
        for (int n = 0; n < 9; n++) begin
            pulse({1'b0, n[2:0], n < 8, 11'h0}, 1'b0, osc, 1'b1);
            cnt = 0;
            repeat (512) begin
                cyc(1);
                cnt += core_clock_enable;
            end
            chk("pulses", 10'(512 >> (n % 8)), 10'(cnt));
            chk("ratio", {7'h0, n[2:0]}, {7'h0, slowdown_ratio});
        end
        for (int r = 0; r < 2; r++) begin
            pulse({r[0], 15'h3800}, 1'b0, osc, 1'b1);
            raise_irq = 1'b1;
            cyc(1);
            raise_irq = 1'b0;
            cyc(2);
            chk("slow_en", {9'h0, !r[0]}, {9'h0, core_slowdown_enable});
            chk("roi", {9'h0, r[0]}, {9'h0, return_on_interrupt});
            drop_irq = 1'b1;
            cyc(1);
            drop_irq = 1'b0;
        end
        tally_and_finish();
    end
endmodule : testbench
